/* File: core/tmsc_pkg.sv */
// Purpose: Shared constants of the timer mode and status control block.
// Assumes: Byte-wide registers on an 8-bit address port.
// Notes: Flag vectors hold bits 7 to 3 of the status register in order.
package tmsc_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h11;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h12;
  localparam logic [7:0] ADDR_STATUS = 8'h13;
  localparam logic [7:0] ADDR_CAP1_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CAP1_LOW = 8'h15;
  localparam logic [7:0] ADDR_CMP1_HIGH = 8'h16;
  localparam logic [7:0] ADDR_CMP1_LOW = 8'h17;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h19;
  localparam logic [7:0] ADDR_ALT_HIGH = 8'h1a;
  localparam logic [7:0] ADDR_ALT_LOW = 8'h1b;
  localparam logic [7:0] ADDR_CAP2_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_CAP2_LOW = 8'h1d;
  localparam logic [7:0] ADDR_CMP2_HIGH = 8'h1e;
  localparam logic [7:0] ADDR_CMP2_LOW = 8'h1f;
  // Control register one bit positions.
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LEVEL2 = 2;
  localparam int C1_CAP1_EDGE = 1;
  localparam int C1_LEVEL1 = 0;
  // Control register two bit positions.
  localparam int C2_CMP1_PIN_EN = 7;
  localparam int C2_CMP2_PIN_EN = 6;
  localparam int C2_SINGLE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_CAP2_EDGE = 1;
  localparam int C2_EXT_EDGE = 0;
  // Status register: disable bit and flag vector indices.
  localparam int ST_DISABLE = 2;
  localparam int FL_CAP1 = 4;
  localparam int FL_CMP1 = 3;
  localparam int FL_OVF = 2;
  localparam int FL_CAP2 = 1;
  localparam int FL_CMP2 = 0;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Clock select codes and prescaler masks.
  localparam logic [1:0] SEL_DIV4 = 2'h0;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h2;
  localparam logic [1:0] SEL_EXT = 2'h3;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV8 = 3'h7;
endpackage

/* File: core/tmsc_timer.sv */
// Purpose: Mode control, flags and counter of a 16-bit free-running timer.
// Assumes: Pins are asynchronous and are synchronised here; bus is on clk.
// Notes: Compare output pins are an output level plus an output enable.
// How it works
// R1: Compare one pin enabled by its bit.
// R2: Compare two pin enabled by its bit.
// R3: Capture edge starts one pulse on compare one.
// R4: Pwm: compare one width, compare two period.
// R5: Clock select picks div4, div2, div8, external.
// R6: No external pin means counter stops when the external clock is selected.
// R7: Capture two edge chosen by its bit.
// R8: External clock edge chosen by its bit.
// R9: Capture one or pwm period sets flag.
// R10: Capture one flag cleared by status, low read.
// R11: Compare one match sets flag, cleared likewise.
// R12: Wrap to zero sets overflow flag, cleared likewise.
// R13: Alternate counter access never clears overflow.
// R14: Capture two sets flag, cleared likewise.
// R15: Compare two match sets flag, cleared likewise.
// R16: Disable freezes prescaler and counter, drops output pin enables.
// R17: Registers stay accessible while disabled.
// R18: Software writes zero to reserved bits.
// R19: Capture flag with enable raises interrupt.
// R20: Capture one edge chosen by its bit.
// R21: Counter is 16-bit up-counter on ticks.
// R22: Clear needs flag seen by status read.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tmsc_timer #(
  parameter bit HAS_EXT_CLOCK = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic cap1InPin,
  input wire logic cap2InPin,
  input wire logic extClockPin,
  output logic cmp1OutPin,
  output logic cmp1OutPinOe,
  output logic cmp2OutPin,
  output logic cmp2OutPinOe,
  output logic timerIrq
);
  import tmsc_pkg::*;

  logic [7:0] ctrlOne_ff;
  logic [7:0] ctrlTwo_ff;
  logic disable_ff;
  logic [4:0] flags_ff;
  logic [4:0] armed_ff;
  logic [2:0] prescale_ff;
  logic [15:0] counter_ff;
  logic [15:0] cap1_ff;
  logic [15:0] cap2_ff;
  logic [15:0] cmp1_ff;
  logic [15:0] cmp2_ff;
  logic cmp1Level_ff;
  logic cmp2Level_ff;
  logic [7:0] rdata_ff;
  logic oe1_ff;
  logic oe2_ff;
  logic irq_ff;
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic [2:0] prev_ff;
  wire logic [2:0] pinIn = {extClockPin, cap2InPin, cap1InPin};

  // Two flip-flops per pin, then one more stage kept for edge detection.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= pinIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
          prev_ff[gi] <= syncB_ff[gi];
        end
      end
    end
  endgenerate

  wire logic [2:0] riseEdge = syncB_ff & ~prev_ff;
  wire logic [2:0] fallEdge = ~syncB_ff & prev_ff;
  wire logic cap1Edge = ctrlOne_ff[C1_CAP1_EDGE] ? riseEdge[0] : fallEdge[0]; // [R20]
  wire logic cap2Edge = ctrlTwo_ff[C2_CAP2_EDGE] ? riseEdge[1] : fallEdge[1]; // [R7]
  wire logic extEdge = ctrlTwo_ff[C2_EXT_EDGE] ? riseEdge[2] : fallEdge[2]; // [R8]

  // Bus decode.
  wire logic wrCtrlOne = regWr && (regAddr == ADDR_CTRL_ONE);
  wire logic wrCtrlTwo = regWr && (regAddr == ADDR_CTRL_TWO);
  wire logic wrStatus = regWr && (regAddr == ADDR_STATUS);
  wire logic rdStatus = regRd && (regAddr == ADDR_STATUS);
  wire logic acc = regWr || regRd;
  wire logic accCap1Low = acc && (regAddr == ADDR_CAP1_LOW);
  wire logic accCmp1Low = acc && (regAddr == ADDR_CMP1_LOW);
  wire logic accCntLow = acc && (regAddr == ADDR_CNT_LOW);
  wire logic accAltLow = acc && (regAddr == ADDR_ALT_LOW);
  wire logic accCap2Low = acc && (regAddr == ADDR_CAP2_LOW);
  wire logic accCmp2Low = acc && (regAddr == ADDR_CMP2_LOW);
  wire logic wrCmp1High = regWr && (regAddr == ADDR_CMP1_HIGH);
  wire logic wrCmp1Low = regWr && (regAddr == ADDR_CMP1_LOW);
  wire logic wrCmp2High = regWr && (regAddr == ADDR_CMP2_HIGH);
  wire logic wrCmp2Low = regWr && (regAddr == ADDR_CMP2_LOW);
  // Writing either counter low byte resets the counter, even while disabled.
  wire logic cntWrite = regWr && ((regAddr == ADDR_CNT_LOW) || (regAddr == ADDR_ALT_LOW)); // [R17]

  // Prescaler and clock selection.
  wire logic [1:0] clkSel = ctrlTwo_ff[C2_CLK_SEL_HI:C2_CLK_SEL_LO];
  wire logic [2:0] divMask = (clkSel == SEL_DIV2) ? MASK_DIV2 :
                             (clkSel == SEL_DIV8) ? MASK_DIV8 : MASK_DIV4;
  wire logic preTick = ((prescale_ff & divMask) == divMask);
  wire logic extTick = HAS_EXT_CLOCK && extEdge; // [R6]
  wire logic tick = !disable_ff && ((clkSel == SEL_EXT) ? extTick : preTick); // [R5] [R16]

  // Counter and compare events.
  wire logic pwmMode = ctrlTwo_ff[C2_PWM];
  wire logic opmMode = ctrlTwo_ff[C2_SINGLE_PULSE] && !pwmMode;
  wire logic [15:0] cntInc = counter_ff + 16'h0001; // [R21]
  wire logic cmp1Hit = tick && (cntInc == cmp1_ff);
  wire logic cmp2Hit = tick && (cntInc == cmp2_ff);
  wire logic pwmReload = pwmMode && cmp2Hit; // [R4]
  wire logic opmStart = opmMode && cap1Edge; // [R3]
  wire logic ovfHit = tick && (counter_ff == CNT_MAX) && !pwmReload;
  // A trigger edge while disabled must not restart the frozen counter.
  wire logic opmReload = opmStart && !disable_ff; // [R16]
  wire logic [15:0] nxt_counter = (cntWrite || pwmReload || opmReload) ? CNT_RESET :
                                  tick ? cntInc : counter_ff;

  // Flags: a set in the same cycle as a clear wins.
  wire logic [4:0] flagSet;
  assign flagSet[FL_CAP1] = (cap1Edge && !pwmMode) || pwmReload; // [R9]
  assign flagSet[FL_CMP1] = cmp1Hit && !pwmMode; // [R11]
  assign flagSet[FL_OVF] = ovfHit; // [R12]
  assign flagSet[FL_CAP2] = cap2Edge; // [R14]
  assign flagSet[FL_CMP2] = cmp2Hit && !pwmMode; // [R15]
  wire logic [4:0] clrAcc;
  assign clrAcc[FL_CAP1] = accCap1Low; // [R10]
  assign clrAcc[FL_CMP1] = accCmp1Low;
  assign clrAcc[FL_OVF] = accCntLow; // [R13]
  assign clrAcc[FL_CAP2] = accCap2Low;
  assign clrAcc[FL_CMP2] = accCmp2Low;
  // Only flags seen by the status read are armed, so later events survive.
  wire logic [4:0] flagClr = armed_ff & clrAcc; // [R22]
  wire logic [4:0] nxt_flags = flagSet | (flags_ff & ~flagClr);
  wire logic [4:0] nxt_armed = rdStatus ? flags_ff : (armed_ff & ~clrAcc);

  // Compare pin levels.
  wire logic lvl1 = ctrlOne_ff[C1_LEVEL1];
  wire logic lvl2 = ctrlOne_ff[C1_LEVEL2];
  wire logic force1 = wrCtrlOne && regWdata[C1_FORCE1];
  wire logic force2 = wrCtrlOne && regWdata[C1_FORCE2];
  wire logic nxt_cmp1Level = (pwmReload || opmStart) ? lvl2 :
                             cmp1Hit ? lvl1 :
                             (force1 && !pwmMode && !opmMode) ? regWdata[C1_LEVEL1] :
                             cmp1Level_ff; // [R3] [R4]
  wire logic nxt_cmp2Level = (cmp2Hit && !pwmMode) ? lvl2 :
                             force2 ? regWdata[C1_LEVEL2] : cmp2Level_ff;
  wire logic nxt_oe1 = ctrlTwo_ff[C2_CMP1_PIN_EN] && !disable_ff; // [R1] [R16]
  wire logic nxt_oe2 = ctrlTwo_ff[C2_CMP2_PIN_EN] && !disable_ff; // [R2] [R16]
  wire logic nxt_irq = (ctrlOne_ff[C1_CAP_IRQ_EN] && (flags_ff[FL_CAP1] || flags_ff[FL_CAP2])) ||
                       (ctrlOne_ff[C1_CMP_IRQ_EN] && (flags_ff[FL_CMP1] || flags_ff[FL_CMP2])) ||
                       (ctrlOne_ff[C1_OVF_IRQ_EN] && flags_ff[FL_OVF]); // [R19]

  // Read mux; reserved status bits and unmapped addresses read zero.
  wire logic [7:0] statusRd = {flags_ff, disable_ff, 2'h0}; // [R18]
  wire logic [7:0] rdMux =
    (regAddr == ADDR_CTRL_ONE) ? ctrlOne_ff :
    (regAddr == ADDR_CTRL_TWO) ? ctrlTwo_ff :
    (regAddr == ADDR_STATUS) ? statusRd :
    (regAddr == ADDR_CAP1_HIGH) ? cap1_ff[15:8] :
    (regAddr == ADDR_CAP1_LOW) ? cap1_ff[7:0] :
    (regAddr == ADDR_CMP1_HIGH) ? cmp1_ff[15:8] :
    (regAddr == ADDR_CMP1_LOW) ? cmp1_ff[7:0] :
    ((regAddr == ADDR_CNT_HIGH) || (regAddr == ADDR_ALT_HIGH)) ? counter_ff[15:8] :
    ((regAddr == ADDR_CNT_LOW) || (regAddr == ADDR_ALT_LOW)) ? counter_ff[7:0] :
    (regAddr == ADDR_CAP2_HIGH) ? cap2_ff[15:8] :
    (regAddr == ADDR_CAP2_LOW) ? cap2_ff[7:0] :
    (regAddr == ADDR_CMP2_HIGH) ? cmp2_ff[15:8] :
    (regAddr == ADDR_CMP2_LOW) ? cmp2_ff[7:0] : 8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlOne_ff <= CTRL_RESET;
      ctrlTwo_ff <= CTRL_RESET;
      disable_ff <= 1'b0;
      cmp1_ff <= CMP_RESET;
      cmp2_ff <= CMP_RESET;
      rdata_ff <= 8'h00;
    end else begin
      if (wrCtrlOne) begin
        ctrlOne_ff <= regWdata;
      end
      if (wrCtrlTwo) begin
        ctrlTwo_ff <= regWdata;
      end
      if (wrStatus) begin
        disable_ff <= regWdata[ST_DISABLE]; // [R16]
      end
      if (wrCmp1High) begin
        cmp1_ff[15:8] <= regWdata;
      end
      if (wrCmp1Low) begin
        cmp1_ff[7:0] <= regWdata;
      end
      if (wrCmp2High) begin
        cmp2_ff[15:8] <= regWdata;
      end
      if (wrCmp2Low) begin
        cmp2_ff[7:0] <= regWdata;
      end
      rdata_ff <= regRd ? rdMux : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale_ff <= 3'h0;
      counter_ff <= CNT_RESET;
      cap1_ff <= 16'h0000;
      cap2_ff <= 16'h0000;
      flags_ff <= 5'h00;
      armed_ff <= 5'h00;
    end else begin
      if (!disable_ff) begin
        prescale_ff <= prescale_ff + 3'h1; // [R16]
      end
      counter_ff <= nxt_counter; // [R21]
      if (cap1Edge && !pwmMode) begin
        cap1_ff <= counter_ff;
      end
      if (cap2Edge) begin
        cap2_ff <= counter_ff;
      end
      flags_ff <= nxt_flags;
      armed_ff <= nxt_armed;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp1Level_ff <= 1'b0;
      cmp2Level_ff <= 1'b0;
      oe1_ff <= 1'b0;
      oe2_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      cmp1Level_ff <= nxt_cmp1Level;
      cmp2Level_ff <= nxt_cmp2Level;
      oe1_ff <= nxt_oe1;
      oe2_ff <= nxt_oe2;
      irq_ff <= nxt_irq;
    end
  end

  assign regRdata = rdata_ff;
  assign cmp1OutPin = cmp1Level_ff;
  assign cmp2OutPin = cmp2Level_ff;
  assign cmp1OutPinOe = oe1_ff;
  assign cmp2OutPinOe = oe2_ff;
  assign timerIrq = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pin1_gate: assert property (!ctrlTwo_ff[C2_CMP1_PIN_EN] |=> !cmp1OutPinOe) // [R1]
    else $error("compare one pin driven while its enable is clear");
  a_pin2_gate: assert property (!ctrlTwo_ff[C2_CMP2_PIN_EN] |=> !cmp2OutPinOe) // [R2]
    else $error("compare two pin driven while its enable is clear");
  a_pulse_start: assert property (opmStart |=> cmp1OutPin == $past(lvl2)) // [R3]
    else $error("single pulse did not start with level two");
  a_pwm_period: assert property (pwmReload && !cntWrite |=> counter_ff == CNT_RESET) // [R4]
    else $error("pwm period end did not reload the counter");
  a_div2_rate: assert property (tick && clkSel == SEL_DIV2 && !wrCtrlTwo |=> !tick) // [R5]
    else $error("divide by two ticked on consecutive cycles");
  a_ext_absent: assert property (!HAS_EXT_CLOCK && clkSel == SEL_EXT |-> !tick) // [R6]
    else $error("counter ticked with no external clock pin");
  a_cap2_flag: assert property (cap2Edge |=> flags_ff[FL_CAP2]) // [R14]
    else $error("capture two edge did not set its flag");
  a_cap1_flag: assert property (cap1Edge && !pwmMode |=> flags_ff[FL_CAP1]) // [R9]
    else $error("capture one edge did not set its flag");
  a_cmp1_flag: assert property (cmp1Hit && !pwmMode |=> flags_ff[FL_CMP1]) // [R11]
    else $error("compare one match did not set its flag");
  a_cmp2_flag: assert property (cmp2Hit && !pwmMode |=> flags_ff[FL_CMP2]) // [R15]
    else $error("compare two match did not set its flag");
  a_ovf_flag: assert property (tick && counter_ff == CNT_MAX && !pwmReload |=> flags_ff[FL_OVF]) // [R12]
    else $error("counter wrap did not set the overflow flag");
  a_alt_keeps: assert property (flags_ff[FL_OVF] && accAltLow |=> flags_ff[FL_OVF]) // [R13]
    else $error("alternate counter access cleared overflow");
  a_clear_armed: assert property (flags_ff[FL_CAP1] && !armed_ff[FL_CAP1] |=> flags_ff[FL_CAP1]) // [R10]
    else $error("capture one flag cleared without a status read");
  a_freeze_count: assert property (disable_ff && !cntWrite |=> $stable(counter_ff)) // [R16]
    else $error("counter moved while disabled");
  a_irq_capture: assert property (ctrlOne_ff[C1_CAP_IRQ_EN] && flags_ff[FL_CAP1] |=> timerIrq) // [R19]
    else $error("capture flag with enable did not raise interrupt");
endmodule
`default_nettype wire

/* File: dv/tmsc_pin_model.sv */
// Purpose: Drives the capture and external clock pins of the timer.
// Assumes: Pins change just after a rising clk edge.
// Notes: The external clock stands low between bursts of pulses.
`timescale 1ns/1ns
`default_nettype none
module tmsc_pin_model (
  input wire logic clk,
  output logic cap1InPin,
  output logic cap2InPin,
  output logic extClockPin
);
  initial begin
    cap1InPin = 1'b0;
    cap2InPin = 1'b0;
    extClockPin = 1'b0;
  end
  // Each level is held 8 clk so that the synchroniser never drops an edge.
  task automatic setPin(input int which, input logic level);
    @(posedge clk);
    if (which == 1) begin
      cap1InPin <= level;
    end else if (which == 2) begin
      cap2InPin <= level;
    end else begin
      extClockPin <= level;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic extPulses(input int n);
    repeat (n) begin
      setPin(0, 1'b1);
      setPin(0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the timer mode and status control block.
// Assumes: The bus master changes strobes right after rising clk edges.
// Notes: A second instance without the external clock pin shares the bus.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tmsc_pkg::*;
  logic clk, reset, regWr, regRd, hiSeen, loSeen;
  logic [7:0] regAddr, regWdata, rdataNoExt, rdataB, c0, c1, m, low;
  wire logic [7:0] regRdata, regRdataNoExt;
  wire logic cap1InPin, cap2InPin, extClockPin;
  wire logic cmp1OutPin, cmp1OutPinOe, cmp2OutPin, cmp2OutPinOe, timerIrq;
  int failures, testsRun;
  int divs[3] = '{4, 2, 8};
  tmsc_timer DUT (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cap1InPin(cap1InPin),
    .cap2InPin(cap2InPin), .extClockPin(extClockPin), .cmp1OutPin(cmp1OutPin),
    .cmp1OutPinOe(cmp1OutPinOe), .cmp2OutPin(cmp2OutPin), .cmp2OutPinOe(cmp2OutPinOe),
    .timerIrq(timerIrq));
  tmsc_timer #(.HAS_EXT_CLOCK(1'b0)) dutNoExt (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdataNoExt), .cap1InPin(cap1InPin), .cap2InPin(cap2InPin),
    .extClockPin(extClockPin), .cmp1OutPin(), .cmp1OutPinOe(), .cmp2OutPin(),
    .cmp2OutPinOe(), .timerIrq());
  tmsc_pin_model pins (.clk(clk), .cap1InPin(cap1InPin), .cap2InPin(cap2InPin),
    .extClockPin(extClockPin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
    rdataNoExt = regRdataNoExt;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic endTest(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    failures = 0;
    testsRun = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rc(ADDR_STATUS, 8'h00);
    rc(ADDR_CTRL_TWO, CTRL_RESET);
    rc(ADDR_CMP1_HIGH, 8'h80);
    rc(ADDR_CMP2_LOW, 8'h00);
    rc(8'h00, 8'h00);
    wr(ADDR_CTRL_TWO, 8'h4b);
    rc(ADDR_CTRL_TWO, 8'h4b);
    endTest("registers");
    // A span of 16 divider periods always holds 16 ticks, whatever the phase.
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_CTRL_TWO, {4'h0, s[1:0], 2'b00});
      rd(ADDR_CNT_LOW, c0);
      cyc(16 * divs[s] - 2);
      rd(ADDR_CNT_LOW, c1);
      check(c1 - c0, 8'h10);
    end
    wr(ADDR_CTRL_TWO, 8'h0d);
    rd(ADDR_CNT_LOW, c0);
    rdataB = rdataNoExt;
    pins.extPulses(16);
    rd(ADDR_CNT_LOW, c1);
    check(c1 - c0, 8'h10);
    check(rdataNoExt, rdataB);
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_CTRL_TWO, 8'h0c | 8'(e));
      rd(ADDR_CNT_LOW, c0);
      pins.setPin(0, 1'b1);
      rd(ADDR_CNT_LOW, c1);
      check(c1 - c0, 8'(e));
      pins.setPin(0, 1'b0);
      rd(ADDR_CNT_LOW, c0);
      check(c0 - c1, 8'(1 - e));
    end
    endTest("clocks");
    wr(ADDR_CTRL_TWO, 8'hc4);
    wr(ADDR_STATUS, 8'h04);
    rd(ADDR_CNT_LOW, c0);
    cyc(40);
    rc(ADDR_CNT_LOW, c0);
    check({6'h0, cmp1OutPinOe, cmp2OutPinOe}, 8'h00);
    wr(ADDR_CMP1_LOW, 8'h33);
    rc(ADDR_CMP1_LOW, 8'h33);
    wr(ADDR_STATUS, 8'h00);
    endTest("disable");
    wr(ADDR_CMP1_HIGH, 8'h00);
    wr(ADDR_CMP1_LOW, 8'h02);
    wr(ADDR_CMP2_HIGH, 8'h00);
    wr(ADDR_CMP2_LOW, 8'h04);
    wr(ADDR_CTRL_ONE, 8'h05);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL_TWO, p ? 8'hc4 : 8'h04);
      wr(ADDR_CNT_LOW, 8'h00);
      cyc(30);
      rd(ADDR_STATUS, c0);
      check(c0 & 8'h48, 8'h48);
      check({cmp1OutPinOe, cmp2OutPinOe}, {p[0], p[0]});
      check({cmp1OutPin & p[0], cmp2OutPin & p[0]}, {p[0], p[0]});
      wr(ADDR_CMP1_LOW, 8'h02);
      rd(ADDR_CMP2_LOW, c1);
      rd(ADDR_STATUS, c0);
      check(c0 & 8'h48, 8'h00);
    end
    wr(ADDR_CTRL_ONE, 8'h18);
    cyc(1);
    check({6'h0, cmp1OutPin, cmp2OutPin}, 8'h00);
    wr(ADDR_STATUS, 8'h04);
    cyc(2);
    check({6'h0, cmp1OutPinOe, cmp2OutPinOe}, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    endTest("compare");
    wr(ADDR_CNT_LOW, 8'h00);
    cyc(20);
    rd(ADDR_CNT_LOW, c1);
    rd(ADDR_STATUS, c0);
    check(c0 & 8'h20, 8'h20);
    rd(ADDR_ALT_LOW, c1);
    rd(ADDR_STATUS, c0);
    check(c0 & 8'h20, 8'h20);
    rd(ADDR_CNT_LOW, c1);
    rd(ADDR_STATUS, c0);
    check(c0 & 8'h20, 8'h00);
    endTest("overflow");
    for (int i = 1; i < 3; i++) begin
      m = (i == 1) ? 8'h80 : 8'h10;
      low = (i == 1) ? ADDR_CAP1_LOW : ADDR_CAP2_LOW;
      for (int e = 0; e < 2; e++) begin
        wr(ADDR_CTRL_ONE, 8'h80 | 8'((i == 1) ? e << 1 : 0));
        wr(ADDR_CTRL_TWO, 8'h04 | 8'((i == 2) ? e << 1 : 0));
        pins.setPin(i, 1'b1);
        rd(ADDR_STATUS, c0);
        check(c0 & m, e ? m : 8'h00);
        pins.setPin(i, 1'b0);
        rd(ADDR_STATUS, c0);
        check(c0 & m, m);
        check({7'h0, timerIrq}, 8'h01);
        if (e == 0) begin
          rd(low, c1);
        end else begin
          wr(low, 8'h00);
        end
        rd(ADDR_STATUS, c0);
        check(c0 & m, 8'h00);
        cyc(2);
        check({7'h0, timerIrq}, 8'h00);
      end
    end
    endTest("capture");
    wr(ADDR_CTRL_ONE, 8'h01);
    wr(ADDR_CTRL_TWO, 8'h94);
    wr(ADDR_CNT_LOW, 8'h00);
    hiSeen = 1'b0;
    loSeen = 1'b0;
    repeat (64) begin
      @(posedge clk);
      #1;
      hiSeen |= cmp1OutPin;
      loSeen |= !cmp1OutPin;
    end
    check({6'h0, hiSeen, loSeen}, 8'h03);
    rd(ADDR_STATUS, c0);
    check(c0 & 8'h80, 8'h80);
    endTest("pwm");
    wr(ADDR_CTRL_ONE, 8'h06);
    wr(ADDR_CMP1_LOW, 8'h08);
    wr(ADDR_CTRL_TWO, 8'ha4);
    pins.setPin(1, 1'b1);
    check({7'h0, cmp1OutPin}, 8'h01);
    cyc(40);
    check({7'h0, cmp1OutPin}, 8'h00);
    cyc(100);
    check({7'h0, cmp1OutPin}, 8'h00);
    endTest("single pulse");
    test_done();
  end
endmodule
`default_nettype wire
